// File: logic/reset_recovery_watchdog_seq.sv
// Reset, stop recovery and watchdog sequencer of the system integration
// unit. Assumes the CPU core shares i_mclk; supply and reset pin are async.
//
// Summary of operation
// - Low supply resets; vector from FFFE/FFFF
// - Break loads vector from FFFC/FFFD
// - Timebase rollover vectors FFDC/FFDD, wakes stop
// - Stop exit gates clocks 4096 cycles
// - Short recovery bit cuts delay to 32
// - Low-voltage reset holds clocks 4096 cycles
// - Reset pin low during low supply, stabilization
// - Pin released 32 cycles after stabilization
// - CPU released 64 cycles after stabilization
// - Low-voltage reset sets its status flag
// - Illegal opcode resets, sets bad opcode flag
// - Stop with stop disabled is illegal opcode
// - Fetch from unmapped address resets, sets flag
// - Data access to unmapped address never resets
// - Break-wait flag: set, write zero, reset clear
// - Reset vector fetch clears watchdog prescaler
// - Watchdog disable, rate follow config bits
// - Any write to FFFF clears watchdog counter
// - Reading FFFF returns reset vector low byte
// - Watchdog never interrupts, only resets
`timescale 1ns/1ps
`include "reset_seq_consts.svh"
`default_nettype none
module reset_recovery_watchdog_seq #(
  parameter int WDOG_W = 18,
  parameter int WDOG_LONG = 262128,
  parameter int WDOG_SHORT = 8176,
  parameter int PRE_W = 4,
  parameter logic [7:0] RESET_VEC_LO = 8'h00
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_low_voltage,
  input wire logic i_rst_pin,
  output logic o_rst_pin_o,
  output logic o_rst_pin_oe,
  input wire logic [15:0] i_cpu_addr,
  input wire logic i_opcode_fetch,
  input wire logic i_vector_fetch,
  input wire logic i_opcode_illegal,
  input wire logic i_stop_exec,
  input wire logic i_addr_unmapped,
  input wire logic i_break_irq,
  input wire logic i_wait_mode,
  input wire logic i_tbm_rollover,
  input wire logic i_ext_irq,
  input wire logic [15:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  output logic o_clk_en,
  output logic o_cpu_hold,
  output logic o_vec_load,
  output logic [15:0] o_vec_addr,
  output logic o_wdog_disable,
  output logic o_wdog_rate_sel
);
  // Two-flop synchronisers for the supply comparator and the reset pin
  logic lv_s1_r, lv_s2_r, pin_s1_r, pin_s2_r;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lv_s1_r <= 1'b0;
      lv_s2_r <= 1'b0;
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
    end else begin
      lv_s1_r <= i_low_voltage;
      lv_s2_r <= lv_s1_r;
      pin_s1_r <= i_rst_pin;
      pin_s2_r <= pin_s1_r;
    end
  end

  reset_seq_pkg::seq_state_t st_r, st_nxt;
  logic [11:0] cnt_r, cnt_nxt;
  logic [7:0] cfg_r, rst_stat_r, rst_stat_nxt;
  logic bw_r;
  logic [WDOG_W-1:0] wdog_r;
  logic [PRE_W-1:0] pre_r;

  // Register decode
  wire wr_cfg = i_reg_wr && (i_reg_addr == `ADDR_CONFIG);
  wire wr_brk = i_reg_wr && (i_reg_addr == `ADDR_BREAK_STATUS);
  wire wr_wdog = i_reg_wr && (i_reg_addr == `ADDR_WDOG_CLEAR);
  wire short_recovery_sel = cfg_r[`CFG_SHORT_REC];
  wire stop_en = cfg_r[`CFG_STOP_EN];
  wire running = (st_r == reset_seq_pkg::ST_RUN);
  // Interrupts and vectors wait while a supply or pin reset is pending
  wire run_ok = running && !lv_s2_r && pin_s2_r;

  // Reset causes seen while running, in priority order
  wire bad_op = running && i_opcode_fetch &&
    (i_opcode_illegal || (i_stop_exec && !stop_en));
  // Only opcode fetches count; data accesses fall through untouched
  wire bad_addr = running && i_opcode_fetch && i_addr_unmapped &&
    !bad_op;
  wire [WDOG_W-1:0] wdog_limit = o_wdog_rate_sel ?
    WDOG_W'(WDOG_SHORT - 1) : WDOG_W'(WDOG_LONG - 1);
  wire wdog_expire = running && !o_wdog_disable &&
    (wdog_r == wdog_limit) && (&pre_r);
  wire int_rst = bad_op || bad_addr || wdog_expire;
  wire stop_go = running && i_opcode_fetch && i_stop_exec && stop_en;
  wire wake = i_ext_irq || i_tbm_rollover || !pin_s2_r;
  wire [11:0] rec_last = short_recovery_sel ?
    12'(`SHORT_REC_CYC - 1) : 12'(`STAB_CYC - 1);
  wire cnt_at_rec = (cnt_r == rec_last);
  wire cnt_at_stab = (cnt_r == 12'(`STAB_CYC - 1));
  wire cnt_at_pin = (cnt_r == 12'(`PIN_REL_CYC - 1));
  wire cnt_at_cpu = (cnt_r == 12'(`CPU_REL_CYC - 1));

  // Sequencer; cnt_r is the single delay counter for every phase
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r + 12'h001;
    rst_stat_nxt = rst_stat_r;
    if (lv_s2_r) begin
      st_nxt = reset_seq_pkg::ST_LV_HOLD;
      cnt_nxt = 12'h000;
      rst_stat_nxt = 8'h00;
      rst_stat_nxt[`RST_LOW_VOLT] = 1'b1;
    end else begin
      unique case (st_r)
        reset_seq_pkg::ST_RUN: begin
          cnt_nxt = 12'h000;
          if (!pin_s2_r) begin
            st_nxt = reset_seq_pkg::ST_EXT_HOLD;
            rst_stat_nxt = 8'h00;
            rst_stat_nxt[`RST_PIN] = 1'b1;
          end else if (int_rst) begin
            st_nxt = reset_seq_pkg::ST_POST;
            rst_stat_nxt = 8'h00;
            rst_stat_nxt[`RST_BAD_OP] = bad_op;
            rst_stat_nxt[`RST_BAD_ADDR] = bad_addr;
            rst_stat_nxt[`RST_WDOG] = wdog_expire;
          end else if (stop_go) begin
            st_nxt = reset_seq_pkg::ST_STOP;
          end
        end
        reset_seq_pkg::ST_LV_HOLD: begin
          // Supply back above trip: start the stabilization count
          st_nxt = reset_seq_pkg::ST_LV_STAB;
          cnt_nxt = 12'h000;
        end
        reset_seq_pkg::ST_LV_STAB: begin
          if (cnt_at_stab) begin
            st_nxt = reset_seq_pkg::ST_POST;
            cnt_nxt = 12'h000;
          end
        end
        reset_seq_pkg::ST_EXT_HOLD: begin
          cnt_nxt = 12'h000;
          if (pin_s2_r) begin
            st_nxt = reset_seq_pkg::ST_POST;
          end
        end
        reset_seq_pkg::ST_POST: begin
          if (cnt_at_cpu) begin
            st_nxt = reset_seq_pkg::ST_RUN;
          end
        end
        reset_seq_pkg::ST_STOP: begin
          cnt_nxt = 12'h000;
          if (wake) begin
            st_nxt = reset_seq_pkg::ST_STOP_REC;
          end
        end
        reset_seq_pkg::ST_STOP_REC: begin
          if (cnt_at_rec) begin
            st_nxt = reset_seq_pkg::ST_RUN;
            cnt_nxt = 12'h000;
          end
        end
      endcase
    end
  end

  // Pin, clock and CPU controls are decoded from the next state so the
  // outputs can come straight from flops without an extra cycle of lag
  wire lv_phase = (st_nxt == reset_seq_pkg::ST_LV_HOLD) ||
    (st_nxt == reset_seq_pkg::ST_LV_STAB);
  wire post_pin = (st_nxt == reset_seq_pkg::ST_POST) &&
    (cnt_nxt < 12'(`PIN_REL_CYC));
  wire pin_oe_nxt = lv_phase || post_pin;
  wire clk_en_nxt = !lv_phase &&
    (st_nxt != reset_seq_pkg::ST_STOP) &&
    (st_nxt != reset_seq_pkg::ST_STOP_REC);
  wire cpu_hold_nxt = (st_nxt != reset_seq_pkg::ST_RUN) &&
    (st_nxt != reset_seq_pkg::ST_STOP) &&
    (st_nxt != reset_seq_pkg::ST_STOP_REC);
  wire rst_done = (st_r == reset_seq_pkg::ST_POST) && cnt_at_cpu &&
    !lv_s2_r;
  wire brk_go = run_ok && i_break_irq && !int_rst;
  wire tbm_go = run_ok && i_tbm_rollover && !int_rst && !brk_go;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= reset_seq_pkg::ST_POST;
      cnt_r <= 12'h000;
      rst_stat_r <= `RST_STAT_RESET;
      o_rst_pin_oe <= 1'b1;
      o_clk_en <= 1'b1;
      o_cpu_hold <= 1'b1;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      rst_stat_r <= rst_stat_nxt;
      o_rst_pin_oe <= pin_oe_nxt;
      o_clk_en <= clk_en_nxt;
      o_cpu_hold <= cpu_hold_nxt;
    end
  end

  // Open-drain reset pin only ever pulls low
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rst_pin_o <= 1'b0;
    end else begin
      o_rst_pin_o <= 1'b0;
    end
  end

  // Vector selection: reset outranks break, break outranks timebase
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_vec_load <= 1'b0;
      o_vec_addr <= `VEC_RESET;
    end else begin
      o_vec_load <= rst_done || brk_go || tbm_go;
      if (rst_done) begin
        o_vec_addr <= `VEC_RESET;
      end else if (brk_go) begin
        o_vec_addr <= `VEC_BREAK;
      end else if (tbm_go) begin
        o_vec_addr <= `VEC_TIMEBASE;
      end
    end
  end

  // Configuration and watchdog controls
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_r <= `CFG_RESET;
      o_wdog_disable <= 1'b0;
      o_wdog_rate_sel <= 1'b0;
    end else begin
      if (wr_cfg) begin
        cfg_r <= i_reg_wdata;
      end
      o_wdog_disable <= cfg_r[`CFG_WDOG_DIS];
      o_wdog_rate_sel <= cfg_r[`CFG_WDOG_RATE];
    end
  end

  // Break-wait flag: a break in wait mode wins over a same-cycle write of zero
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bw_r <= 1'b0;
    end else if (cpu_hold_nxt) begin
      bw_r <= 1'b0;
    end else if (i_break_irq && i_wait_mode) begin
      bw_r <= 1'b1;
    end else if (wr_brk && !i_reg_wdata[`BRK_WAIT]) begin
      bw_r <= 1'b0;
    end
  end

  // Watchdog: prescaler ticks the counter; timeout only causes a reset
  wire vec_fetch_seen = i_vector_fetch && (i_cpu_addr == `VEC_RESET);
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_r <= '0;
      wdog_r <= '0;
    end else begin
      if (vec_fetch_seen || !running) begin
        pre_r <= '0;
      end else begin
        pre_r <= pre_r + PRE_W'(1);
      end
      if (wr_wdog || !running || o_wdog_disable) begin
        wdog_r <= '0;
      end else if (&pre_r) begin
        wdog_r <= wdog_r + WDOG_W'(1);
      end
    end
  end

  // Read port; unmapped addresses read zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (i_reg_addr)
      `ADDR_CONFIG: rd_mux = cfg_r;
      `ADDR_RESET_STATUS: rd_mux = rst_stat_r;
      `ADDR_BREAK_STATUS: rd_mux[`BRK_WAIT] = bw_r;
      `ADDR_WDOG_CLEAR: rd_mux = RESET_VEC_LO;
      default: rd_mux = 8'h00;
    endcase
  end
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 8'h00;
    end else begin
      o_reg_rdata <= i_reg_rd ? rd_mux : 8'h00;
    end
  end

  lv_stab_end_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (st_r == reset_seq_pkg::ST_LV_STAB) && cnt_at_stab && !lv_s2_r
    |=> st_r == reset_seq_pkg::ST_POST && cnt_r == 12'h000)
    else $error("stabilization did not end after 4096 cycles");
  pin_low_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (st_r == reset_seq_pkg::ST_LV_HOLD) |=> o_rst_pin_oe && !o_clk_en)
    else $error("reset pin or clocks wrong in low supply");
  pin_release_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (st_r == reset_seq_pkg::ST_POST) && cnt_at_pin && !lv_s2_r
    |=> !o_rst_pin_oe)
    else $error("reset pin not released after 32 cycles");
  cpu_release_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (st_r == reset_seq_pkg::ST_POST) && cnt_at_cpu && !lv_s2_r
    |=> !o_cpu_hold && o_vec_load && o_vec_addr == `VEC_RESET)
    else $error("cpu not released to reset vector after 64 cycles");
  lv_flag_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    lv_s2_r |=> rst_stat_r[`RST_LOW_VOLT] ##1 o_cpu_hold)
    else $error("low voltage flag not set");
  bad_op_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    run_ok && i_opcode_fetch && i_opcode_illegal
    |=> st_r == reset_seq_pkg::ST_POST && rst_stat_r[`RST_BAD_OP])
    else $error("illegal opcode did not give bad opcode reset");
  stop_illegal_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    running && !lv_s2_r && pin_s2_r && i_opcode_fetch && i_stop_exec
    && !stop_en
    |=> st_r == reset_seq_pkg::ST_POST && rst_stat_r[`RST_BAD_OP])
    else $error("disabled stop did not give bad opcode reset");
  data_unmapped_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    running && !lv_s2_r && pin_s2_r && !i_opcode_fetch && !wdog_expire
    |=> st_r == reset_seq_pkg::ST_RUN)
    else $error("data access caused a reset");
  stop_rec_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (st_r == reset_seq_pkg::ST_STOP_REC) && !lv_s2_r && !o_clk_en
    && cnt_r == rec_last |=> running && o_clk_en)
    else $error("stop recovery length wrong");
  bw_clear_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    wr_brk && !i_reg_wdata[`BRK_WAIT] && !(i_break_irq && i_wait_mode)
    |=> !bw_r)
    else $error("break wait flag not cleared by write of zero");
  wdog_clear_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    wr_wdog |=> wdog_r == '0)
    else $error("watchdog not cleared by write");
  wdog_read_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    i_reg_rd && i_reg_addr == `ADDR_WDOG_CLEAR |=> o_reg_rdata == RESET_VEC_LO)
    else $error("watchdog address read wrong");
  brk_vec_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    run_ok && i_break_irq && !int_rst |=> o_vec_addr == `VEC_BREAK)
    else $error("break did not load its vector");
  tbm_vec_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    run_ok && i_tbm_rollover && !i_break_irq && !int_rst
    |=> o_vec_load && o_vec_addr == `VEC_TIMEBASE)
    else $error("timebase did not load its vector");
  pre_clear_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    i_vector_fetch && i_cpu_addr == `VEC_RESET |=> pre_r == '0)
    else $error("reset vector fetch did not clear prescaler");
  cfg_follow_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (cfg_r[`CFG_WDOG_DIS] |=> o_wdog_disable) and
    (cfg_r[`CFG_WDOG_RATE] |=> o_wdog_rate_sel))
    else $error("watchdog controls do not follow configuration");
endmodule
`default_nettype wire

// File: logic/reset_seq_consts.svh
// Constants for the reset, stop recovery and watchdog sequencer.
// Assumes the oscillator reference clock is the module clock.
`ifndef RESET_SEQ_CONSTS_SVH
`define RESET_SEQ_CONSTS_SVH
// Vector addresses
`define VEC_RESET 16'hfffe
`define VEC_BREAK 16'hfffc
`define VEC_TIMEBASE 16'hffdc
// Register map
`define ADDR_WDOG_CLEAR 16'hffff
`define ADDR_BREAK_STATUS 16'hfe00
`define ADDR_RESET_STATUS 16'hfe01
`define ADDR_CONFIG 16'hfe1f
// Config field positions
`define CFG_SHORT_REC 0
`define CFG_WDOG_DIS 1
`define CFG_WDOG_RATE 2
`define CFG_STOP_EN 3
`define CFG_RESET 8'h00
// Reset status field positions
`define RST_LOW_VOLT 1
`define RST_BAD_ADDR 3
`define RST_BAD_OP 4
`define RST_WDOG 5
`define RST_PIN 6
`define RST_STAT_RESET 8'h00
// Break status field position
`define BRK_WAIT 1
// Timing in oscillator reference cycles
`define STAB_CYC 4096
`define SHORT_REC_CYC 32
`define PIN_REL_CYC 32
`define CPU_REL_CYC 64
`endif

// File: logic/reset_seq_pkg.sv
// Types for the reset, stop recovery and watchdog sequencer.
// Assumes nothing beyond the constants header.
package reset_seq_pkg;
  typedef enum logic [2:0] {
    ST_RUN, ST_LV_HOLD, ST_LV_STAB, ST_EXT_HOLD, ST_POST, ST_STOP,
    ST_STOP_REC
  } seq_state_t;
endpackage

// File: test/cpu_pin_model.sv
// Model of the CPU core's vector fetch and the pulled-up reset pin.
// Assumes the sequencer drives the pin open drain, all on i_mclk.
`timescale 1ns/1ps
`default_nettype none
module cpu_pin_model (
  input wire logic i_mclk,
  input wire logic i_oe,
  input wire logic i_o,
  input wire logic i_vec_load,
  input wire logic [15:0] i_vec_addr,
  output logic o_pin,
  output logic o_vfetch,
  output logic [15:0] o_vaddr
);
  // Pull-up: a released pin reads high, never the last driven value
  assign o_pin = (i_oe && !i_o) ? 1'b0 : 1'b1;
  initial begin
    o_vfetch = 1'b0;
    o_vaddr = 16'h0000;
  end
  // Fetch the vector pair the cycle after a load; idle address toggles
  always @(posedge i_mclk) begin
    o_vfetch <= i_vec_load;
    o_vaddr <= i_vec_load ? i_vec_addr : ~o_vaddr;
  end
endmodule
`default_nettype wire

// File: test/tb_reset_recovery_watchdog_seq.sv
// Self-checking bench for the reset, recovery and watchdog sequencer.
// Assumes cpu_pin_model stands in for the CPU core and the reset pin.
`timescale 1ns/1ps
`include "reset_seq_consts.svh"
`default_nettype none
module tb_reset_recovery_watchdog_seq;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic lv = 0, fet = 0, ill = 0, stp = 0, unm = 0, brk = 0, wm = 0;
  logic timebase_unit = 0, ext = 0, wr = 0, rd = 0, rd_q = 0;
  logic [15:0] ta = 16'h0000, ra = 16'h0000;
  logic [7:0] wd = 8'h00;
  logic pin, vf, oe, po, hold, clk_en, vl, wdis, wrs;
  logic [15:0] va, vaddr, cpu_a;
  logic [7:0] rdata;
  logic [31:0] seed = 32'h13;
  logic [15:0] exp_vec[$];
  logic [7:0] exp_rd[$];
  int err_total = 0, n_compared = 0, tp, tc, c;
  assign cpu_a = vf ? va : ta;
  always #4 i_mclk = ~i_mclk;
  cpu_pin_model partner (.i_mclk(i_mclk), .i_oe(oe), .i_o(po),
    .i_vec_load(vl), .i_vec_addr(vaddr), .o_pin(pin), .o_vfetch(vf),
    .o_vaddr(va));
  // Short watchdog counts keep the timeout scenario brief
  reset_recovery_watchdog_seq #(.WDOG_LONG(64), .WDOG_SHORT(16),
    .PRE_W(2), .RESET_VEC_LO(8'ha5)) DUT (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_low_voltage(lv),
    .i_rst_pin(pin), .o_rst_pin_o(po), .o_rst_pin_oe(oe),
    .i_cpu_addr(cpu_a), .i_opcode_fetch(fet), .i_vector_fetch(vf),
    .i_opcode_illegal(ill), .i_stop_exec(stp), .i_addr_unmapped(unm),
    .i_break_irq(brk), .i_wait_mode(wm), .i_tbm_rollover(timebase_unit),
    .i_ext_irq(ext), .i_reg_addr(ra), .i_reg_wdata(wd), .i_reg_wr(wr),
    .i_reg_rd(rd), .o_reg_rdata(rdata), .o_clk_en(clk_en),
    .o_cpu_hold(hold), .o_vec_load(vl), .o_vec_addr(vaddr),
    .o_wdog_disable(wdis), .o_wdog_rate_sel(wrs));
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction
  task automatic chk(input logic [15:0] g, e, input string m);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  task automatic wrr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    ra <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge i_mclk);
    wr <= 1'b0;
  endtask
  task automatic rdr(input logic [15:0] a, input logic [7:0] e);
    exp_rd.push_back(e);
    @(posedge i_mclk);
    ra <= a;
    rd <= 1'b1;
    @(posedge i_mclk);
    rd <= 1'b0;
  endtask
  task automatic fetch(input logic i, s, u);
    @(posedge i_mclk);
    fet <= 1'b1;
    ill <= i;
    stp <= s;
    unm <= u;
    ta <= rnd();
    @(posedge i_mclk);
    fet <= 1'b0;
    ill <= 1'b0;
    stp <= 1'b0;
    unm <= 1'b0;
  endtask
  // Cycles to pin release (tp) and to CPU release (tc)
  task automatic meas();
    c = 0;
    tp = 0;
    while (hold !== 1'b0 && c < 9000) begin
      @(negedge i_mclk);
      c++;
      if (oe === 1'b0 && tp == 0) tp = c;
    end
    tc = c;
    chk(16'(tc - tp), 16'd32, "pin to cpu release");
  endtask
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // An unexpected vector load is forced to mismatch
  always @(negedge i_mclk) begin
    if (vl === 1'b1) begin
      if (exp_vec.size() == 0) exp_vec.push_back(~vaddr);
      chk(vaddr, exp_vec.pop_front(), "vector");
    end
    if (rd_q) chk(rdata, exp_rd.pop_front(), "read data");
    rd_q = rd;
  end
  initial begin
    step(40000);
    err_total++;
    $display("FAIL %0t timeout", $time);
    test_done();
  end
  initial begin
    exp_vec.push_back(`VEC_RESET);
    step(8);
    i_rst_n <= 1'b1;
    meas();
    tend("power-on");
    wrr(`ADDR_CONFIG, 8'h02);
    @(posedge i_mclk);
    lv <= 1'b1;
    step(20);
    chk(pin, 1'b0, "pin during low supply");
    chk(clk_en, 1'b0, "clocks during low supply");
    exp_vec.push_back(`VEC_RESET);
    lv <= 1'b0;
    step(2000);
    chk(oe, 1'b1, "pin during stabilization");
    chk(clk_en, 1'b0, "clocks during stabilization");
    meas();
    chk(16'(tp >= 2128 && tp <= 2136), 16'h1, "stab length");
    rdr(`ADDR_RESET_STATUS, 8'h02);
    tend("low voltage");
    wrr(`ADDR_CONFIG, 8'h02);
    exp_vec.push_back(`VEC_TIMEBASE);
    @(posedge i_mclk);
    timebase_unit <= 1'b1;
    @(posedge i_mclk);
    timebase_unit <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      exp_vec.push_back(`VEC_BREAK);
      @(posedge i_mclk);
      wm <= 1'b1;
      brk <= 1'b1;
      @(posedge i_mclk);
      brk <= 1'b0;
      wm <= 1'b0;
      step(3);
      rdr(`ADDR_BREAK_STATUS, 8'h02);
      if (i == 0) begin
        wrr(`ADDR_BREAK_STATUS, 8'h00);
        rdr(`ADDR_BREAK_STATUS, 8'h00);
      end
    end
    @(posedge i_mclk);
    unm <= 1'b1;
    ta <= rnd();
    step(20);
    chk(hold, 1'b0, "data access to unmapped");
    unm <= 1'b0;
    tend("vectors and break");
    for (int k = 0; k < 3; k++) begin
      wrr(`ADDR_CONFIG, 8'h02);
      exp_vec.push_back(`VEC_RESET);
      fetch(k == 0, k == 1, k == 2);
      step(2);
      chk(hold, 1'b1, "internal reset");
      meas();
      rdr(`ADDR_RESET_STATUS, k == 2 ? 8'h08 : 8'h10);
      if (k == 0) rdr(`ADDR_BREAK_STATUS, 8'h00);
    end
    tend("internal resets");
    for (int s = 0; s < 2; s++) begin
      wrr(`ADDR_CONFIG, s ? 8'h0b : 8'h0a);
      fetch(1'b0, 1'b1, 1'b0);
      step(3);
      chk(clk_en, 1'b0, "stopped clocks");
      ext <= 1'b1;
      @(posedge i_mclk);
      ext <= 1'b0;
      c = 0;
      while (clk_en !== 1'b1 && c < 6000) begin
        @(negedge i_mclk);
        c++;
      end
      tc = s ? 32 : 4096;
      chk(16'(c >= tc && c <= tc + 6), 16'h1, "stop recovery");
    end
    tend("stop recovery");
    wrr(`ADDR_CONFIG, 8'h06);
    step(2);
    chk(wdis, 1'b1, "watchdog disable");
    chk(wrs, 1'b1, "watchdog rate");
    wrr(`ADDR_CONFIG, 8'h00);
    step(2);
    chk(wdis, 1'b0, "watchdog enable");
    chk(wrs, 1'b0, "watchdog rate clear");
    repeat (8) begin
      step(30);
      wrr(`ADDR_WDOG_CLEAR, 8'(rnd()));
    end
    chk(hold, 1'b0, "kicked watchdog");
    exp_vec.push_back(`VEC_RESET);
    c = 0;
    while (hold !== 1'b1 && c < 2000) begin
      @(negedge i_mclk);
      c++;
    end
    chk(hold, 1'b1, "watchdog timeout");
    meas();
    wrr(`ADDR_CONFIG, 8'h02);
    rdr(`ADDR_RESET_STATUS, 8'h20);
    rdr(`ADDR_WDOG_CLEAR, 8'ha5);
    rdr(16'h1234, 8'h00);
    step(2);
    // Mid-run reset: registers return to their reset values
    i_rst_n <= 1'b0;
    step(3);
    chk(hold, 1'b1, "hold during reset");
    chk(oe, 1'b1, "pin during reset");
    exp_vec.push_back(`VEC_RESET);
    i_rst_n <= 1'b1;
    meas();
    rdr(`ADDR_CONFIG, 8'h00);
    rdr(`ADDR_RESET_STATUS, 8'h00);
    step(4);
    chk(16'(exp_vec.size() + exp_rd.size()), 16'h0, "pending results");
    tend("watchdog and registers");
    test_done();
  end
endmodule
`default_nettype wire
